// ### actc_top.sv
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Overview of operation
// (R1) format bit picks high or right justify
// (R2) channel codes 0-10 route, others float
// (R3) source field picks external or internal signal
// (R4) internal source disconnects external channel path
// (R5) clock field divides by powers of two
// (R6) software enables gain amp when used
// (R7) bandgap input switches reference pin off
// (R8) reference select, pin path off otherwise
// (R9) gain field picks four gains
// (R10) trigger bit picks software or pwm
// (R11) software keeps delay zero unless enabled
// (R12) pwm bit picks period or duty
// (R13) duty field picks channel, 1x is two
// (R14) compare interrupt only for opamp source
// (R15) delay lasts count system clocks
// (R16) delay starts on flag rising edge
// (R17) unimplemented bits ignore writes, read zero
// (R18) start high then low begins conversion
// (R19) disabled converter keeps result and bounds
// (R20) end of conversion sets flag, clears busy
// (R21) expired delay starts one conversion
// (R22) compare once per new result
module actc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pwm_period_flag,
	input wire logic [2:0] pwm_duty_flag,
	input wire logic [11:0] core_result, // sample from the analog core
	output logic [10:0] ext_channel_on, // one-hot analog switch per input
	output logic [5:0] int_source_on, // opamp, avdd, avdd/2, vr, vr/2, ground
	output logic conv_clk_en, // one pulse per conversion clock
	output logic gain_amp_on,
	output logic gain_amp_ref_pin_on,
	output logic bandgap_on,
	output logic [2:0] ref_on, // avdd, pin, amp output
	output logic [1:0] gain_code,
	output logic conv_done_irq,
	output logic compare_irq,
	output logic conv_busy_flag
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ctrl0_ff, nxt_ctrl0; // busy bit kept apart in busy_ff
	logic [7:0] insel_ff, nxt_insel;
	logic [7:0] pga_ff, nxt_pga;
	logic [7:0] trig_ff, nxt_trig;
	logic [7:0] dly_ff, nxt_dly;
	logic [7:0] bgap_ff, nxt_bgap;
	logic [11:0] res_ff, nxt_res, lob_ff, nxt_lob, hib_ff, nxt_hib;
	logic done_ff, nxt_done, cmp_ff, nxt_cmp;
	logic busy_ff, nxt_busy;
	logic wr_ff, nxt_wr; // pending write data phase
	logic [7:0] wa_ff, nxt_wa;
	logic [31:0] rd_ff, nxt_rd;
	logic [6:0] div_ff, nxt_div;
	logic [7:0] dcnt_ff, nxt_dcnt, ccnt_ff, nxt_ccnt;
	logic [2:0] flag_s1_ff, flag_s2_ff, flag_s3_ff; // pwm flag synchronisers
	actc_pkg::actc_state_t st_ff, nxt_st;
	logic start_prev_ff;
	logic trig_sel, trig_rise, sw_start, go, conv_tick;
	// justify a 12-bit value into low/high bytes
	function automatic logic [15:0] justify(input logic [11:0] v, input logic rj);
		justify = rj ? {4'h0, v} : {v, 4'h0};
	endfunction : justify
	// pick 12-bit value back from a byte write
	function automatic logic [11:0] put_byte(input logic [11:0] v, input logic [7:0] b, input logic hi,
		input logic rj);
		logic [15:0] w;
		w = justify(v, rj);
		if (hi)
			w[15:8] = b;
		else
			w[7:0] = b;
		put_byte = rj ? w[11:0] : w[15:4];
	endfunction : put_byte
	// ----------------------------------------
	// bus slave: zero wait state, always okay
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_ff;
	logic take;
	assign take = hsel && hready && htrans == actc_pkg::HTRANS_NONSEQ;
	// read data mux, registered into the data phase
	logic [15:0] rj_res, rj_lob, rj_hib;
	always_comb
	begin
		rj_res = justify(res_ff, ctrl0_ff[actc_pkg::B_JUST]); // (R1)
		rj_lob = justify(lob_ff, ctrl0_ff[actc_pkg::B_JUST]);
		rj_hib = justify(hib_ff, ctrl0_ff[actc_pkg::B_JUST]);
		nxt_wr = take && hwrite;
		nxt_wa = take ? haddr : wa_ff;
		nxt_rd = 32'h0; // unmapped reads give zero
		if (take && !hwrite)
		begin
			unique case (haddr)
				actc_pkg::ADDR_CTRL0: nxt_rd[7:0] = ctrl0_ff | {1'b0, busy_ff, 6'h0};
				actc_pkg::ADDR_INSEL: nxt_rd[7:0] = insel_ff;
				actc_pkg::ADDR_PGA: nxt_rd[7:0] = pga_ff;
				actc_pkg::ADDR_TRIG: nxt_rd[7:0] = trig_ff;
				actc_pkg::ADDR_DLY: nxt_rd[7:0] = dly_ff;
				actc_pkg::ADDR_RESL: nxt_rd[7:0] = rj_res[7:0];
				actc_pkg::ADDR_RESH: nxt_rd[7:0] = rj_res[15:8];
				actc_pkg::ADDR_LOBL: nxt_rd[7:0] = rj_lob[7:0];
				actc_pkg::ADDR_LOBH: nxt_rd[7:0] = rj_lob[15:8];
				actc_pkg::ADDR_HIBL: nxt_rd[7:0] = rj_hib[7:0];
				actc_pkg::ADDR_HIBH: nxt_rd[7:0] = rj_hib[15:8];
				actc_pkg::ADDR_BGAP: nxt_rd[7:0] = bgap_ff;
				actc_pkg::ADDR_STAT: nxt_rd[1:0] = {cmp_ff, done_ff};
				default: nxt_rd = 32'h0;
			endcase
		end
	end
	// ----------------------------------------
	// control registers and result store
	// ----------------------------------------
	logic cmp_hit;
	always_comb
	begin
		nxt_ctrl0 = ctrl0_ff;
		nxt_insel = insel_ff;
		nxt_pga = pga_ff;
		nxt_trig = trig_ff;
		nxt_dly = dly_ff;
		nxt_bgap = bgap_ff;
		nxt_lob = lob_ff;
		nxt_hib = hib_ff;
		nxt_res = res_ff;
		nxt_done = done_ff;
		nxt_cmp = cmp_ff;
		if (wr_ff)
		begin
			unique case (wa_ff)
				actc_pkg::ADDR_CTRL0: nxt_ctrl0 = hwdata[7:0] & actc_pkg::MASK_CTRL0; // (R17)
				actc_pkg::ADDR_INSEL: nxt_insel = hwdata[7:0] & actc_pkg::MASK_INSEL; // (R17)
				actc_pkg::ADDR_PGA: nxt_pga = hwdata[7:0] & actc_pkg::MASK_PGA; // (R17)
				actc_pkg::ADDR_TRIG: nxt_trig = hwdata[7:0] & actc_pkg::MASK_TRIG; // (R17)
				actc_pkg::ADDR_DLY: nxt_dly = hwdata[7:0];
				actc_pkg::ADDR_BGAP: nxt_bgap = hwdata[7:0] & actc_pkg::MASK_BGAP; // (R17)
				// bound writes honour the format; held while disabled
				actc_pkg::ADDR_LOBL: if (ctrl0_ff[actc_pkg::B_EN])
					nxt_lob = put_byte(lob_ff, hwdata[7:0], 1'b0, ctrl0_ff[actc_pkg::B_JUST]); // (R19)
				actc_pkg::ADDR_LOBH: if (ctrl0_ff[actc_pkg::B_EN])
					nxt_lob = put_byte(lob_ff, hwdata[7:0], 1'b1, ctrl0_ff[actc_pkg::B_JUST]); // (R19)
				actc_pkg::ADDR_HIBL: if (ctrl0_ff[actc_pkg::B_EN])
					nxt_hib = put_byte(hib_ff, hwdata[7:0], 1'b0, ctrl0_ff[actc_pkg::B_JUST]); // (R19)
				actc_pkg::ADDR_HIBH: if (ctrl0_ff[actc_pkg::B_EN])
					nxt_hib = put_byte(hib_ff, hwdata[7:0], 1'b1, ctrl0_ff[actc_pkg::B_JUST]); // (R19)
				actc_pkg::ADDR_STAT:
				begin
					nxt_done = done_ff & ~hwdata[0];
					nxt_cmp = cmp_ff & ~hwdata[1];
				end
				default: nxt_dly = dly_ff;
			endcase
		end
		// completion: set wins over a clear in the same cycle
		if (st_ff == actc_pkg::ACTC_CONV && conv_tick && ccnt_ff == 8'h1)
		begin
			nxt_res = core_result;
			nxt_done = 1'b1; // (R20)
			if (cmp_hit)
				nxt_cmp = 1'b1; // (R14) (R22)
		end
	end
	// compare against the new sample with current bounds
	always_comb
	begin
		unique case ({trig_ff[actc_pkg::B_CHI], trig_ff[actc_pkg::B_CLO]})
			actc_pkg::CMP_INSIDE: cmp_hit = lob_ff < core_result && core_result < hib_ff; // (R14)
			actc_pkg::CMP_LOW: cmp_hit = core_result <= lob_ff; // (R14)
			actc_pkg::CMP_HIGH: cmp_hit = core_result >= hib_ff; // (R14)
			default: cmp_hit = core_result <= lob_ff || core_result >= hib_ff; // (R14)
		endcase
		cmp_hit = cmp_hit && insel_ff[7:5] == actc_pkg::SRC_OPAMP; // (R14)
	end
	// ----------------------------------------
	// trigger path
	// ----------------------------------------
	// flag_s1 is read only by flag_s2
	always_comb
	begin
		logic [1:0] dsel;
		dsel = trig_ff[1:0];
		if (!trig_ff[actc_pkg::B_PWSEL])
			trig_sel = 1'b0; // period path handled below
		else if (dsel == 2'h0)
			trig_sel = flag_s3_ff[0] == 1'b0 && flag_s2_ff[0]; // (R13) (R16)
		else if (dsel == 2'h1)
			trig_sel = flag_s3_ff[1] == 1'b0 && flag_s2_ff[1]; // (R13) (R16)
		else
			trig_sel = flag_s3_ff[2] == 1'b0 && flag_s2_ff[2]; // (R13) (R16)
	end
	logic per_s1_ff, per_s2_ff, per_s3_ff;
	assign trig_rise = trig_ff[actc_pkg::B_PWSEL] ? trig_sel : (per_s2_ff && !per_s3_ff); // (R12) (R16)
	assign sw_start = start_prev_ff && !ctrl0_ff[actc_pkg::B_START]; // (R18)
	// ----------------------------------------
	// sequencer: wait for delay, then convert
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_dcnt = dcnt_ff;
		nxt_ccnt = ccnt_ff;
		nxt_busy = busy_ff;
		go = 1'b0;
		unique case (st_ff)
			actc_pkg::ACTC_IDLE:
			begin
				if (ctrl0_ff[actc_pkg::B_EN])
				begin
					if (!trig_ff[actc_pkg::B_TSRC] && sw_start)
						go = 1'b1; // (R10) (R18)
					else if (trig_ff[actc_pkg::B_TSRC] && trig_rise)
					begin
						if (trig_ff[actc_pkg::B_DLYEN] && dly_ff != 8'h0)
						begin
							nxt_dcnt = dly_ff; // (R15)
							nxt_st = actc_pkg::ACTC_WAIT;
						end
						else
							go = 1'b1; // (R21)
					end
				end
			end
			actc_pkg::ACTC_WAIT:
			begin
				nxt_dcnt = dcnt_ff - 8'h1; // one per system clock
				if (dcnt_ff == 8'h1)
					go = 1'b1; // (R15) (R21)
			end
			actc_pkg::ACTC_CONV:
			begin
				if (conv_tick)
					nxt_ccnt = ccnt_ff - 8'h1;
				if (conv_tick && ccnt_ff == 8'h1)
				begin
					nxt_busy = 1'b0; // (R20)
					nxt_st = actc_pkg::ACTC_IDLE;
				end
			end
			default: nxt_st = actc_pkg::ACTC_IDLE;
		endcase
		if (go)
		begin
			nxt_busy = 1'b1; // (R18)
			nxt_ccnt = actc_pkg::CONV_CLKS;
			nxt_st = actc_pkg::ACTC_CONV;
		end
	end
	// conversion clock divider
	assign nxt_div = div_ff + 7'h1;
	always_comb
	begin
		logic [6:0] m;
		m = 7'h7f >> (3'h7 - insel_ff[2:0]);
		conv_tick = (div_ff & m) == 7'h0; // (R5)
	end
	// ----------------------------------------
	// analog switch controls
	// ----------------------------------------
	always_comb
	begin
		logic [2:0] src;
		src = insel_ff[7:5];
		ext_channel_on = 11'h0;
		if (src == actc_pkg::SRC_EXT && ctrl0_ff[3:0] <= actc_pkg::CH_LAST)
			ext_channel_on[ctrl0_ff[3:0]] = 1'b1; // (R2) (R4)
		int_source_on = 6'h0;
		if (src != actc_pkg::SRC_EXT)
			int_source_on[(src > 3'h6) ? 3'h5 : src - 3'h1] = 1'b1; // (R3)
		ref_on = pga_ff[3] ? 3'h4 : (pga_ff[3:2] == actc_pkg::REF_PIN ? 3'h2 : 3'h1); // (R8)
	end
	assign conv_clk_en = conv_tick && st_ff == actc_pkg::ACTC_CONV;
	assign gain_amp_on = pga_ff[actc_pkg::B_GAEN];
	assign gain_amp_ref_pin_on = !pga_ff[actc_pkg::B_GAIS]; // (R7)
	assign bandgap_on = bgap_ff[0];
	assign gain_code = pga_ff[1:0]; // (R9)
	assign conv_done_irq = done_ff;
	assign compare_irq = cmp_ff;
	assign conv_busy_flag = busy_ff;
	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl0_ff <= actc_pkg::RST_BYTE;
			insel_ff <= actc_pkg::RST_BYTE;
			pga_ff <= actc_pkg::RST_BYTE;
			trig_ff <= actc_pkg::RST_BYTE;
			dly_ff <= actc_pkg::RST_BYTE;
			bgap_ff <= actc_pkg::RST_BYTE;
			res_ff <= 12'h0;
			lob_ff <= 12'h0;
			hib_ff <= 12'h0;
			done_ff <= 1'b0;
			cmp_ff <= 1'b0;
			busy_ff <= 1'b0;
			wr_ff <= 1'b0;
			wa_ff <= 8'h0;
			rd_ff <= 32'h0;
			div_ff <= 7'h0;
			dcnt_ff <= 8'h0;
			ccnt_ff <= 8'h0;
			st_ff <= actc_pkg::ACTC_IDLE;
			start_prev_ff <= 1'b0;
			flag_s1_ff <= 3'h0;
			flag_s2_ff <= 3'h0;
			flag_s3_ff <= 3'h0;
			per_s1_ff <= 1'b0;
			per_s2_ff <= 1'b0;
			per_s3_ff <= 1'b0;
		end
		else
		begin
			ctrl0_ff <= nxt_ctrl0;
			insel_ff <= nxt_insel;
			pga_ff <= nxt_pga;
			trig_ff <= nxt_trig;
			dly_ff <= nxt_dly;
			bgap_ff <= nxt_bgap;
			res_ff <= nxt_res;
			lob_ff <= nxt_lob;
			hib_ff <= nxt_hib;
			done_ff <= nxt_done;
			cmp_ff <= nxt_cmp;
			busy_ff <= nxt_busy;
			wr_ff <= nxt_wr;
			wa_ff <= nxt_wa;
			rd_ff <= nxt_rd;
			div_ff <= nxt_div;
			dcnt_ff <= nxt_dcnt;
			ccnt_ff <= nxt_ccnt;
			st_ff <= nxt_st;
			start_prev_ff <= ctrl0_ff[actc_pkg::B_START];
			flag_s1_ff <= pwm_duty_flag;
			flag_s2_ff <= flag_s1_ff;
			flag_s3_ff <= flag_s2_ff;
			per_s1_ff <= pwm_period_flag;
			per_s2_ff <= per_s1_ff;
			per_s3_ff <= per_s2_ff;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_done_clears_busy: assert property (@(posedge hclk) disable iff (!hresetn) // (R20)
		$rose(done_ff) |-> !busy_ff) else $error("done set while busy");
	chk_start_sets_busy: assert property (@(posedge hclk) disable iff (!hresetn) // (R18)
		(sw_start && ctrl0_ff[actc_pkg::B_EN] && !trig_ff[actc_pkg::B_TSRC] && st_ff == actc_pkg::ACTC_IDLE)
		|=> busy_ff) else $error("start did not set busy");
	chk_ext_off_int: assert property (@(posedge hclk) disable iff (!hresetn) // (R4)
		insel_ff[7:5] != actc_pkg::SRC_EXT |-> ext_channel_on == 11'h0) else $error("external path shorted");
	chk_float_codes: assert property (@(posedge hclk) disable iff (!hresetn) // (R2)
		ctrl0_ff[3:0] > actc_pkg::CH_LAST |-> ext_channel_on == 11'h0) else $error("undefined code routed");
	chk_bandgap_pin: assert property (@(posedge hclk) disable iff (!hresetn) // (R7)
		pga_ff[actc_pkg::B_GAIS] |-> !gain_amp_ref_pin_on) else $error("pin not switched off");
	chk_ref_pin_off: assert property (@(posedge hclk) disable iff (!hresetn) // (R8)
		pga_ff[3:2] != actc_pkg::REF_PIN |-> !ref_on[1]) else $error("ref pin not off");
	chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn) // (R17)
		(insel_ff[4:3] == 2'h0) && (pga_ff[6:5] == 2'h0) && !trig_ff[2]) else $error("reserved bit set");
	chk_hold_disabled: assert property (@(posedge hclk) disable iff (!hresetn) // (R19)
		!ctrl0_ff[actc_pkg::B_EN] && st_ff == actc_pkg::ACTC_IDLE |=> $stable(res_ff) && $stable(lob_ff))
		else $error("result changed while disabled");
	chk_delay_len: assert property (@(posedge hclk) disable iff (!hresetn) // (R15)
		$rose(st_ff == actc_pkg::ACTC_WAIT) && dly_ff == 8'h2 |-> ##2 busy_ff ##0 !$past(busy_ff))
		else $error("delay length wrong");
endmodule : actc_top

// ### actc_pkg.sv
package actc_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL0 = 8'h00; // start, busy, enable, format, channel
	localparam logic [7:0] ADDR_INSEL = 8'h04; // input source, clock divide
	localparam logic [7:0] ADDR_PGA = 8'h08; // gain amp and reference
	localparam logic [7:0] ADDR_TRIG = 8'h0c; // trigger and compare control
	localparam logic [7:0] ADDR_DLY = 8'h10; // delay count
	localparam logic [7:0] ADDR_RESL = 8'h14; // result low byte
	localparam logic [7:0] ADDR_RESH = 8'h18; // result high byte
	localparam logic [7:0] ADDR_LOBL = 8'h1c; // lower bound low byte
	localparam logic [7:0] ADDR_LOBH = 8'h20; // lower bound high byte
	localparam logic [7:0] ADDR_HIBL = 8'h24; // upper bound low byte
	localparam logic [7:0] ADDR_HIBH = 8'h28; // upper bound high byte
	localparam logic [7:0] ADDR_BGAP = 8'h2c; // bandgap enable
	localparam logic [7:0] ADDR_STAT = 8'h30; // done / compare flags, write 1 clears
	// ----------------------------------------
	// writable masks (unimplemented bits read zero)
	// ----------------------------------------
	localparam logic [7:0] MASK_CTRL0 = 8'hbf;
	localparam logic [7:0] MASK_INSEL = 8'he7;
	localparam logic [7:0] MASK_PGA = 8'h9f;
	localparam logic [7:0] MASK_TRIG = 8'hfb;
	localparam logic [7:0] MASK_BGAP = 8'h01;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_START = 7;
	localparam int B_BUSY = 6;
	localparam int B_EN = 5;
	localparam int B_JUST = 4;
	localparam int B_GAEN = 7;
	localparam int B_GAIS = 4;
	localparam int B_TSRC = 7;
	localparam int B_DLYEN = 6;
	localparam int B_PWSEL = 5;
	localparam int B_CHI = 4;
	localparam int B_CLO = 3;
	// ----------------------------------------
	// input source codes and misc
	// ----------------------------------------
	localparam logic [2:0] SRC_EXT = 3'h0;
	localparam logic [2:0] SRC_OPAMP = 3'h1;
	localparam logic [3:0] CH_LAST = 4'ha;
	localparam logic [1:0] REF_PIN = 2'h1;
	localparam logic [7:0] CONV_CLKS = 8'h10; // conversion clocks per result
	localparam logic [1:0] CMP_INSIDE = 2'h0;
	localparam logic [1:0] CMP_LOW = 2'h1;
	localparam logic [1:0] CMP_HIGH = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {ACTC_IDLE = 2'h0, ACTC_WAIT = 2'h1, ACTC_CONV = 2'h3} actc_state_t;
endpackage : actc_pkg

// ### actc_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// far side: analog core sample and pwm match flags
// ----------------------------------------
module actc_far_model (
	input wire logic hclk,
	input wire logic conv_busy_flag, // sample is only valid while converting
	input wire logic [11:0] sample_val, // value the core settles on
	input wire logic [3:0] fire, // bit0 period match, bits 3:1 duty match
	output logic [11:0] core_result,
	output logic pwm_period_flag,
	output logic [2:0] pwm_duty_flag
);
	// outside a conversion the core shows the inverse, so a stray capture is caught
	assign core_result = conv_busy_flag ? sample_val : ~sample_val;
	// match flags are levels that follow the pwm timer one clock late
	always_ff @(posedge hclk)
	begin
		pwm_period_flag <= fire[0];
		pwm_duty_flag <= fire[3:1];
	end
endmodule : actc_far_model

// ### adc_channel_trigger_control_test.sv
`timescale 1ns/1ps
module adc_channel_trigger_control_test;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_period_flag, conv_clk_en;
	logic gain_amp_on, gain_amp_ref_pin_on, bandgap_on, conv_done_irq, compare_irq, conv_busy_flag;
	logic [7:0] haddr, q;
	logic [1:0] htrans, gain_code;
	logic [2:0] hsize, pwm_duty_flag, ref_on;
	logic [31:0] hwdata, hrdata;
	logic [11:0] core_result, sample_val;
	logic [10:0] ext_channel_on;
	logic [5:0] int_source_on;
	logic [3:0] fire;
	int num_errors, num_checks;
	// compare cases: mode, sample, expected compare flag (bounds 0x100 and 0x800)
	logic [1:0] cm[8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
	logic [11:0] cs[8] = '{12'h400, 12'h100, 12'h100, 12'h101, 12'h800, 12'h7ff, 12'h050, 12'h400};
	logic ce[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [7:0] amap[4] = '{actc_pkg::ADDR_INSEL, actc_pkg::ADDR_PGA, actc_pkg::ADDR_TRIG, actc_pkg::ADDR_BGAP};
	logic [7:0] mmap[4] = '{actc_pkg::MASK_INSEL, actc_pkg::MASK_PGA, actc_pkg::MASK_TRIG, actc_pkg::MASK_BGAP};
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	actc_top u_actc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pwm_period_flag(pwm_period_flag), .pwm_duty_flag(pwm_duty_flag),
		.core_result(core_result), .ext_channel_on(ext_channel_on), .int_source_on(int_source_on),
		.conv_clk_en(conv_clk_en), .gain_amp_on(gain_amp_on), .gain_amp_ref_pin_on(gain_amp_ref_pin_on),
		.bandgap_on(bandgap_on), .ref_on(ref_on), .gain_code(gain_code), .conv_done_irq(conv_done_irq),
		.compare_irq(compare_irq), .conv_busy_flag(conv_busy_flag));
	actc_far_model u_actc_far_model (.hclk(hclk), .conv_busy_flag(conv_busy_flag), .sample_val(sample_val),
		.fire(fire), .core_result(core_result), .pwm_period_flag(pwm_period_flag), .pwm_duty_flag(pwm_duty_flag));
	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// the whole sequence needs under 15k cycles, so this only trips on a hang
	initial
	begin
		repeat (50000) @(posedge hclk);
		num_errors++;
		tally_and_finish();
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one single ahb-lite transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= actc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rd_chk
	// start bit high then low again
	task automatic sw_start(input logic [7:0] c);
		wr(actc_pkg::ADDR_CTRL0, c | 8'h80);
		wr(actc_pkg::ADDR_CTRL0, c);
	endtask : sw_start
	// follow one conversion: clock pulses while busy and spacing of the first two
	task automatic wait_conv(output int pulses, output int gap);
		int n;
		int first;
		n = 0;
		pulses = 0;
		gap = 0;
		first = -1;
		while (conv_busy_flag !== 1'b1 && n < 300)
		begin
			@(posedge hclk);
			n++;
		end
		// busy is seen one edge after it rose, so the cycle just past already belongs to the conversion
		n = 0;
		while (conv_busy_flag === 1'b1 && n < 5000)
		begin
			if (conv_clk_en === 1'b1)
			begin
				pulses++;
				if (first < 0)
					first = n;
				else if (pulses == 2)
					gap = n - first;
			end
			@(posedge hclk);
			n++;
		end
	endtask : wait_conv
	// raise match flags and count cycles until busy (400 means no start)
	task automatic pwm_trial(input logic [3:0] f, output int lat);
		fire <= f;
		lat = 0;
		while (conv_busy_flag !== 1'b1 && lat < 400)
		begin
			@(posedge hclk);
			lat++;
		end
		fire <= 4'h0;
		repeat (100) @(posedge hclk);
	endtask : pwm_trial
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int p;
		int g;
		int l1;
		int l2;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sample_val = 12'habc;
		fire = 4'h0;
		hresetn = 1'b0;
		num_errors = 0;
		num_checks = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, then writable masks and an unmapped word
		for (int i = 0; i < 13; i++) rd_chk(8'(i * 4), actc_pkg::RST_BYTE);
		chk({hresp, ext_channel_on, ref_on, gain_amp_ref_pin_on}, {1'b0, 11'h001, 3'h1, 1'b1});
		for (int i = 0; i < 4; i++)
		begin
			wr(amap[i], 8'hff);
			rd_chk(amap[i], mmap[i]);
			wr(amap[i], 8'h00);
		end
		wr(8'h3c, 8'hff);
		rd_chk(8'h3c, 8'h00);
		// external channel codes with external source
		for (int i = 0; i < 16; i++)
		begin
			wr(actc_pkg::ADDR_CTRL0, 8'(i));
			@(posedge hclk);
			chk(ext_channel_on, (i <= 10) ? (11'h1 << i) : 11'h0);
		end
		// every source code with channel 3 selected
		wr(actc_pkg::ADDR_CTRL0, 8'h03);
		for (int s = 0; s < 8; s++)
		begin
			wr(actc_pkg::ADDR_INSEL, 8'(s << 5));
			@(posedge hclk);
			chk(ext_channel_on, (s == 0) ? 11'h008 : 11'h0);
			chk(int_source_on, (s == 0) ? 6'h0 : (s >= 6) ? 6'h20 : (6'h1 << (s - 1)));
		end
		// gain amp, reference and gain fields
		for (g = 0; g < 32; g++)
		begin
			wr(actc_pkg::ADDR_PGA, {g[0], 2'b00, g[4:0]});
			@(posedge hclk);
			chk({gain_amp_on, gain_code}, {g[0], g[1:0]});
			chk(ref_on, g[3] ? 3'h4 : g[2] ? 3'h2 : 3'h1);
			chk(gain_amp_ref_pin_on, !g[4]);
		end
		// amp output as reference: software keeps the amp enabled
		wr(actc_pkg::ADDR_PGA, 8'h88);
		@(posedge hclk);
		chk({gain_amp_on, ref_on}, {1'b1, 3'h4});
		wr(actc_pkg::ADDR_BGAP, 8'h01);
		@(posedge hclk);
		chk(bandgap_on, 1'b1);
		// software conversions at two clock divides and both formats
		wr(actc_pkg::ADDR_INSEL, 8'h00);
		sw_start(8'h20);
		wait_conv(p, g);
		chk(p, actc_pkg::CONV_CLKS);
		chk(g, 1);
		rd_chk(actc_pkg::ADDR_RESH, 8'hab);
		rd_chk(actc_pkg::ADDR_RESL, 8'hc0);
		rd_chk(actc_pkg::ADDR_STAT, 8'h01);
		wr(actc_pkg::ADDR_STAT, 8'h01);
		rd_chk(actc_pkg::ADDR_STAT, 8'h00);
		wr(actc_pkg::ADDR_INSEL, 8'h02);
		sw_start(8'h30);
		wait_conv(p, g);
		chk(g, 4);
		chk(conv_busy_flag, 1'b0);
		rd_chk(actc_pkg::ADDR_RESH, 8'h0a);
		rd_chk(actc_pkg::ADDR_RESL, 8'hbc);
		// disabled converter keeps result and bounds
		sample_val = 12'h123;
		sw_start(8'h10);
		wr(actc_pkg::ADDR_LOBH, 8'hff);
		repeat (100) @(posedge hclk);
		rd_chk(actc_pkg::ADDR_RESL, 8'hbc);
		rd_chk(actc_pkg::ADDR_LOBH, 8'h00);
		// pwm period start after two delays: the difference is the count difference
		wr(actc_pkg::ADDR_CTRL0, 8'h20);
		wr(actc_pkg::ADDR_INSEL, 8'h00);
		wr(actc_pkg::ADDR_TRIG, 8'hc0);
		wr(actc_pkg::ADDR_DLY, 8'h02);
		pwm_trial(4'h1, l1);
		wr(actc_pkg::ADDR_DLY, 8'h28);
		pwm_trial(4'h1, l2);
		chk(32'(l2 - l1), 32'd38);
		chk(l1 < 400, 1'b1);
		// duty match with delay off (count kept zero), every channel code
		wr(actc_pkg::ADDR_DLY, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			wr(actc_pkg::ADDR_TRIG, 8'ha0 | 8'(k));
			pwm_trial(4'h2 << ((k > 1) ? 2 : k), l1);
			chk(l1 < 400, 1'b1);
			// a duty flag of a channel not selected must not start
			pwm_trial(4'h2 << ((k == 1 || k == 2) ? 0 : 1), l1);
			chk(l1, 400);
			pwm_trial(4'h1, l1);
			chk(l1, 400);
		end
		wr(actc_pkg::ADDR_TRIG, 8'h00);
		pwm_trial(4'h1, l1);
		chk(l1, 400);
		// compare conditions with the opamp source, then one with the external source, bounds 0x100 and 0x800
		wr(actc_pkg::ADDR_CTRL0, 8'h30);
		wr(actc_pkg::ADDR_LOBH, 8'h01);
		wr(actc_pkg::ADDR_HIBH, 8'h08);
		wr(actc_pkg::ADDR_INSEL, 8'h20);
		for (int i = 0; i < 9; i++)
		begin
			if (i == 8)
				wr(actc_pkg::ADDR_INSEL, 8'h00);
			wr(actc_pkg::ADDR_STAT, 8'h03);
			wr(actc_pkg::ADDR_TRIG, {3'b000, cm[i % 8], 3'b000});
			sample_val = cs[i % 8];
			sw_start(8'h30);
			wait_conv(p, g);
			rd_chk(actc_pkg::ADDR_STAT, {6'h0, (i < 8) && ce[i % 8], 1'b1});
			chk({compare_irq, conv_done_irq}, {(i < 8) && ce[i % 8], 1'b1});
		end
		tally_and_finish();
	end
endmodule : adc_channel_trigger_control_test
